// [shared/pfta_defines.vh]
// Constants for the power feature threshold alarm block.
// Functional notes
// - Critical distortion alarm when distortion exceeds a 0.0-100.0 % limit.
// - Separate warning distortion alarm above its own warning limit.
// - Critical power alarm above a signed, range-dependent limit.
// - Warning power alarm with the same signed, range-dependent limit span.
// - Critical power ratio alarm above a signed limit of -1.00 to 1.00.
// - Warning power ratio alarm above a signed limit of -1.00 to 1.00.
// - Critical line frequency alarm above a 0.0 to 250.0 Hz limit.
// - Warning line frequency alarm above a 0.0 to 250.0 Hz limit.
// - Wiring code 0, 1 or 2; reset value 0.
// - Voltage range 150, 300 or 600 V; reset value is 150 V.
// - Sample every 50 ms; window of 1 to 2000 samples, default 1.
// - Sensitivity 20.0-200.0 %, default 80.0 %, scales teach thresholds.
// - Leaving initial settings level soft resets, returning to monitoring.
// - Threshold code 32761 disables that alarm, so it never sets.
`ifndef PFTA_DEFINES_VH
`define PFTA_DEFINES_VH

`define PFTA_CLK_HZ 20000000
`define PFTA_SAMPLE_MS 50
`define PFTA_SAMPLE_CYCLES 24'hF4240

`define PFTA_OFF_LEVEL 8'h00
`define PFTA_OFF_CONFIG 8'h04
`define PFTA_OFF_WINDOW 8'h08
`define PFTA_OFF_SENS 8'h0C
`define PFTA_OFF_THR0 8'h10
`define PFTA_OFF_ALARM 8'h30
`define PFTA_OFF_ISTAT 8'h34
`define PFTA_OFF_IMASK 8'h38
`define PFTA_LAST_WORD 6'h0E

`define PFTA_LVL_MONITOR 2'h0
`define PFTA_LVL_ADJUST 2'h1
`define PFTA_LVL_INITIAL 2'h2

`define PFTA_CFG_WIRING 1:0
`define PFTA_CFG_VRANGE 3:2
`define PFTA_CFG_I5A 4

`define PFTA_WIRING_RST 2'h0
`define PFTA_WIRING_MAX 2'h2
`define PFTA_VRANGE_RST 2'h0
`define PFTA_VRANGE_MAX 2'h2
`define PFTA_I5A_RST 1'b1

`define PFTA_WIN_RST 11'h001
`define PFTA_WIN_MIN 11'h001
`define PFTA_WIN_MAX 11'h7D0
`define PFTA_SENS_RST 11'h320
`define PFTA_SENS_MIN 11'h0C8
`define PFTA_SENS_MAX 11'h7D0
`define PFTA_SENS_DIV 28'sh00003E8

`define PFTA_THR_OFF 16'h7FF9
`define PFTA_THD_MAX 16'sh03E8
`define PFTA_PW5_MAX 16'sh2A8A
`define PFTA_PWX_MAX 16'sh2208
`define PFTA_RATIO_MAX 16'sh0064
`define PFTA_FREQ_MAX 16'sh09C4

`endif

// [verilog/pfta_cmp.v]
// Critical and warning compare of one feature against its two limits.
`timescale 1ns/1ps
module pfta_cmp #(
    parameter W = 16,
    parameter [W-1:0] OFF = 16'h7FF9
) (
    input wire [W-1:0] value, // Feature value, signed.
    input wire [W-1:0] crit, // Critical limit, signed.
    input wire [W-1:0] warn, // Warning limit, signed.
    output wire crit_hit, // Value above critical limit.
    output wire warn_hit // Value above warning limit.
);
    assign crit_hit = (crit != OFF) &&
        ($signed(value) > $signed(crit));
    assign warn_hit = (warn != OFF) &&
        ($signed(value) > $signed(warn));
endmodule // pfta_cmp

// [verilog/pfta_top.v]
// Threshold alarm evaluation and measurement settings with an APB slave.
`timescale 1ns/1ps
`include "pfta_defines.vh"
module pfta_top #(
    parameter [23:0] SAMPLE_CYCLES = `PFTA_SAMPLE_CYCLES
) (
    input wire pclk, // Bus and block clock.
    input wire presetn, // Asynchronous reset, active low.
    input wire psel, // APB select.
    input wire penable, // APB enable.
    input wire pwrite, // APB direction, high for write.
    input wire [7:0] paddr, // APB byte address.
    input wire [31:0] pwdata, // APB write data.
    output reg [31:0] prdata, // APB read data.
    output reg pready, // APB ready.
    output reg pslverr, // APB error for unmapped address.
    input wire [15:0] feat_thd, // Current distortion, 0.1 % units.
    input wire [15:0] feat_power, // Active power, signed.
    input wire [15:0] feat_power_ratio, // Power ratio, signed, 0.01 units.
    input wire [15:0] feat_freq, // Line frequency, 0.1 Hz units.
    input wire teach_end, // Pulse when teaching completes.
    output reg [7:0] alarm_flags, // Live alarm flags.
    output reg irq, // Interrupt, high while unmasked event set.
    output reg [1:0] wiring_configuration, // Wiring state in force.
    output reg [1:0] voltage_range, // Voltage range in force.
    output reg current_5a, // Current range is 5 A, in force.
    output reg [1:0] settings_level_indicator, // Present settings level.
    output reg soft_reset_pulse // One cycle at software reset.
);
    reg [1:0] cfg_wiring_reg;
    reg [1:0] cfg_vrange_reg;
    reg cfg_i5a_reg;
    reg [10:0] cfg_win_reg;
    reg [10:0] cfg_sens_reg;
    reg [10:0] win_force_reg;
    reg [10:0] sens_force_reg;
    reg [15:0] thr_reg [0:7];
    reg [15:0] peak_reg [0:3];
    reg [23:0] tick_cnt_reg;
    reg [10:0] win_cnt_reg;
    reg [7:0] istat_reg;
    reg [7:0] imask_reg;
    reg [31:0] rd_next;
    reg err_next;
    wire [63:0] feat_bus;
    wire [63:0] cand_bus;
    wire [63:0] scaled_bus;
    wire [7:0] hit;
    wire [5:0] word;
    wire mapped;
    wire commit;
    wire wr;
    wire tick;
    wire win_end;
    wire soft_rst;
    wire in_init;
    wire [7:0] ev_set;
    wire [7:0] ev_clr;
    wire [7:0] istat_next;
    wire [2:0] thr_idx;
    wire thr_sel;
    integer i;
    integer j;

    assign feat_bus = {feat_freq, feat_power_ratio, feat_power, feat_thd};
    assign word = paddr[7:2];
    assign mapped = (paddr[1:0] == 2'h0) && (word <= `PFTA_LAST_WORD);
    assign commit = psel && penable && pready;
    assign wr = commit && pwrite && mapped;
    assign in_init = (settings_level_indicator == `PFTA_LVL_INITIAL);
    assign thr_sel = (word >= 6'h04) && (word <= 6'h0B);
    assign thr_idx = word[2:0] - 3'h4;

    // Leaving the initial level by a level write triggers the soft reset.
    assign soft_rst = wr && (paddr == `PFTA_OFF_LEVEL) && in_init &&
        (pwdata[1:0] != `PFTA_LVL_INITIAL) &&
        (pwdata[1:0] != 2'h3);

    assign tick = (tick_cnt_reg == SAMPLE_CYCLES - 24'h000001);
    assign win_end = tick &&
        (win_cnt_reg == win_force_reg - 11'h001);

    // Hardware event set wins over a same-cycle write-one clear.
    assign ev_set = win_end ? (hit & ~alarm_flags) : 8'h00;
    assign ev_clr = (wr && (paddr == `PFTA_OFF_ISTAT)) ? pwdata[7:0] : 8'h00;
    assign istat_next = (istat_reg & ~ev_clr) | ev_set;

    // Clamp a limit to its legal span, keeping the disable code untouched.
    function [15:0] clamp_thr;
        input [2:0] idx;
        input [15:0] d;
        input i5a;
        reg signed [15:0] lo;
        reg signed [15:0] hi;
        begin
            case (idx[2:1])
                2'h0: begin
                    lo = 16'sh0000;
                    hi = `PFTA_THD_MAX;
                end
                2'h1: begin
                    hi = i5a ? `PFTA_PW5_MAX : `PFTA_PWX_MAX;
                    lo = -hi;
                end
                2'h2: begin
                    hi = `PFTA_RATIO_MAX;
                    lo = -hi;
                end
                default: begin
                    lo = 16'sh0000;
                    hi = `PFTA_FREQ_MAX;
                end
            endcase
            if (d == `PFTA_THR_OFF) begin
                clamp_thr = d;
            end else if ($signed(d) < lo) begin
                clamp_thr = lo;
            end else if ($signed(d) > hi) begin
                clamp_thr = hi;
            end else begin
                clamp_thr = d;
            end
        end
    endfunction

    function [10:0] clamp11;
        input [10:0] d;
        input [10:0] lo;
        input [10:0] hi;
        begin
            if (d < lo) begin
                clamp11 = lo;
            end else if (d > hi) begin
                clamp11 = hi;
            end else begin
                clamp11 = d;
            end
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : feat
            wire [15:0] f;
            wire signed [27:0] prod;
            wire signed [27:0] quo;
            assign f = feat_bus[16*g +: 16];
            // Window peak: first sample of a window restarts it.
            assign cand_bus[16*g +: 16] = ((win_cnt_reg == 11'h000) ||
                ($signed(f) > $signed(peak_reg[g]))) ? f : peak_reg[g];
            assign prod = $signed(f) *
                $signed({1'b0, sens_force_reg});
            assign quo = prod / `PFTA_SENS_DIV;
            assign scaled_bus[16*g +: 16] = quo[15:0];
            pfta_cmp #(
                .W(16),
                .OFF(`PFTA_THR_OFF)
            ) u_cmp (
                .value(cand_bus[16*g +: 16]),
                .crit(thr_reg[2*g]),
                .warn(thr_reg[2*g+1]),
                .crit_hit(hit[2*g]),
                .warn_hit(hit[2*g+1])
            );
        end
    endgenerate

    always @* begin
        rd_next = 32'h00000000;
        err_next = !mapped;
        case (word)
            6'h00: rd_next[1:0] = settings_level_indicator;
            6'h01: rd_next[4:0] = {cfg_i5a_reg, cfg_vrange_reg, cfg_wiring_reg};
            6'h02: rd_next[10:0] = cfg_win_reg;
            6'h03: rd_next[10:0] = cfg_sens_reg;
            6'h0C: rd_next[7:0] = alarm_flags;
            6'h0D: rd_next[7:0] = istat_reg;
            6'h0E: rd_next[7:0] = imask_reg;
            default: begin
                if (thr_sel) begin
                    rd_next[15:0] = thr_reg[thr_idx];
                end
            end
        endcase
        if (!mapped) begin
            rd_next = 32'h00000000;
        end
    end

    // One wait state: ready rises one cycle into the access phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : rd_next;
            pslverr <= err_next;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settings_level_indicator <= `PFTA_LVL_MONITOR;
            cfg_wiring_reg <= `PFTA_WIRING_RST;
            cfg_vrange_reg <= `PFTA_VRANGE_RST;
            cfg_i5a_reg <= `PFTA_I5A_RST;
            cfg_win_reg <= `PFTA_WIN_RST;
            cfg_sens_reg <= `PFTA_SENS_RST;
            imask_reg <= 8'h00;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_rst;
            if (soft_rst) begin
                settings_level_indicator <= `PFTA_LVL_MONITOR;
            end else if (wr && (paddr == `PFTA_OFF_LEVEL) &&
                    (pwdata[1:0] != 2'h3)) begin
                settings_level_indicator <= pwdata[1:0];
            end
            if (wr && in_init && (paddr == `PFTA_OFF_CONFIG)) begin
                if (pwdata[1:0] <= `PFTA_WIRING_MAX) begin
                    cfg_wiring_reg <= pwdata[1:0];
                end
                if (pwdata[3:2] <= `PFTA_VRANGE_MAX) begin
                    cfg_vrange_reg <= pwdata[3:2];
                end
                cfg_i5a_reg <= pwdata[4];
            end
            if (wr && in_init && (paddr == `PFTA_OFF_WINDOW)) begin
                cfg_win_reg <= clamp11(pwdata[10:0], `PFTA_WIN_MIN,
                    `PFTA_WIN_MAX);
            end
            if (wr && in_init && (paddr == `PFTA_OFF_SENS)) begin
                cfg_sens_reg <= clamp11(pwdata[10:0], `PFTA_SENS_MIN,
                    `PFTA_SENS_MAX);
            end
            if (wr && (paddr == `PFTA_OFF_IMASK)) begin
                imask_reg <= pwdata[7:0];
            end
        end
    end

    // Settings in force change only at the soft reset.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wiring_configuration <= `PFTA_WIRING_RST;
            voltage_range <= `PFTA_VRANGE_RST;
            current_5a <= `PFTA_I5A_RST;
            win_force_reg <= `PFTA_WIN_RST;
            sens_force_reg <= `PFTA_SENS_RST;
        end else if (soft_rst) begin
            wiring_configuration <= cfg_wiring_reg;
            voltage_range <= cfg_vrange_reg;
            current_5a <= cfg_i5a_reg;
            win_force_reg <= cfg_win_reg;
            sens_force_reg <= cfg_sens_reg;
        end
    end

    // A bus write to a limit takes precedence over a teach load.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                thr_reg[i] <= `PFTA_THR_OFF;
            end
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                if (wr && thr_sel && (thr_idx == i[2:0])) begin
                    thr_reg[i] <= clamp_thr(i[2:0], pwdata[15:0],
                        current_5a);
                end else if (teach_end && (i[0] == 1'b0)) begin
                    thr_reg[i] <= clamp_thr(i[2:0],
                        scaled_bus[16*(i/2) +: 16], current_5a);
                end
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 24'h000000;
            win_cnt_reg <= 11'h000;
            alarm_flags <= 8'h00;
            for (j = 0; j < 4; j = j + 1) begin
                peak_reg[j] <= 16'h0000;
            end
        end else if (soft_rst) begin
            tick_cnt_reg <= 24'h000000;
            win_cnt_reg <= 11'h000;
            alarm_flags <= 8'h00;
        end else begin
            tick_cnt_reg <= tick ? 24'h000000 :
                tick_cnt_reg + 24'h000001;
            if (tick) begin
                for (j = 0; j < 4; j = j + 1) begin
                    peak_reg[j] <= cand_bus[16*j +: 16];
                end
                win_cnt_reg <= win_end ? 11'h000 :
                    win_cnt_reg + 11'h001;
            end
            if (win_end) begin
                alarm_flags <= hit;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg <= 8'h00;
            irq <= 1'b0;
        end else begin
            istat_reg <= istat_next;
            irq <= |(istat_next & imask_reg);
        end
    end
endmodule // pfta_top

// [dv/pfta_asserts.sv]
// Bus timing and settings level checks for the threshold alarm block.
`timescale 1ns/1ps
module pfta_asserts (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Direction.
    input wire logic [7:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic [1:0] wiring_configuration, // Wiring.
    input wire logic [1:0] settings_level_indicator, // Level.
    input wire logic soft_reset_pulse // Soft reset.
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_lvl_wr;
        psel && penable && pready && pwrite && paddr == 8'h00;
    endsequence
    sequence s_exit;
        s_lvl_wr ##0 (pwdata[1:0] < 2'h2 &&
            settings_level_indicator == 2'h2);
    endsequence
    AST_RDY_WAIT: assert property (psel && penable && !pready
        |=> pready)
        else $error("pready late");
    AST_RDY_ONE: assert property (pready |=> !pready)
        else $error("pready held");
    AST_ERR_RDY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata outside answer");
    AST_EXIT: assert property (s_exit |-> ##[1:2] soft_reset_pulse)
        else $error("no soft reset on level exit");
    AST_PULSE: assert property (soft_reset_pulse |->
        settings_level_indicator == 2'h0 ##1 !soft_reset_pulse)
        else $error("bad soft reset pulse");
    AST_LVL3: assert property (s_lvl_wr ##0 pwdata[1:0] == 2'h3
        |=> $stable(settings_level_indicator))
        else $error("level code 3 taken");
    AST_CFG_HOLD: assert property ($changed(wiring_configuration)
        |-> $past(settings_level_indicator) == 2'h2)
        else $error("wiring changed outside level exit");
endmodule // pfta_asserts
bind pfta_top pfta_asserts pfta_asserts_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wiring_configuration(wiring_configuration),
    .settings_level_indicator(settings_level_indicator),
    .soft_reset_pulse(soft_reset_pulse));

// [dv/pfta_front_model.sv]
// Measurement front end model presenting held feature samples.
`timescale 1ns/1ps
module pfta_front_model (
    input wire logic pclk, // Clock.
    input wire logic [63:0] scene, // Packed features.
    input wire logic teach_req, // Teach request level.
    output logic [15:0] feat_thd, // Distortion.
    output logic [15:0] feat_power, // Power.
    output logic [15:0] feat_power_ratio, // Ratio.
    output logic [15:0] feat_freq, // Frequency.
    output logic teach_end // Teach pulse.
);
    logic req_q = 1'b0;
    always @(posedge pclk) begin
        {feat_freq, feat_power_ratio, feat_power, feat_thd} <= scene;
        req_q <= teach_req;
        teach_end <= teach_req & ~req_q;
    end
endmodule // pfta_front_model

// [dv/pfta_tb.sv]
// Self-checking bench for the threshold alarm block.
`timescale 1ns/1ps
module tb;
    localparam SC = 8;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, irq, current_5a, soft_reset_pulse, teach_end, e;
    logic teach_req = 0;
    logic [63:0] scene = 64'h0;
    logic [15:0] feat_thd, feat_power, feat_power_ratio, feat_freq;
    logic [7:0] alarm_flags;
    logic [1:0] wiring_configuration, voltage_range, settings_level_indicator;
    logic [7:0] ca [6] = '{8'h10, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
    logic [15:0] cw [6] = '{16'h07D0, 16'h4E20, 16'hB1E0, 16'h00C8,
        16'hFF38, 16'h0BB8};
    logic [15:0] ce [6] = '{16'h03E8, 16'h2A8A, 16'hD576, 16'h0064,
        16'hFF9C, 16'h09C4};
    logic [15:0] th [8] = '{16'h01F4, 16'h00C8, 16'h0064, 16'hFFCE,
        16'h0032, 16'h003C, 16'h7FF9, 16'h01F4};
    int failures = 0;
    int num_checks = 0;
    always #25 pclk = ~pclk;
    pfta_top #(.SAMPLE_CYCLES(24'd8)) pfta_top_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .feat_thd(feat_thd), .feat_power(feat_power),
        .feat_power_ratio(feat_power_ratio), .feat_freq(feat_freq),
        .teach_end(teach_end), .alarm_flags(alarm_flags), .irq(irq),
        .wiring_configuration(wiring_configuration),
        .voltage_range(voltage_range), .current_5a(current_5a),
        .settings_level_indicator(settings_level_indicator),
        .soft_reset_pulse(soft_reset_pulse));
    pfta_front_model pfta_front_model_inst (.pclk(pclk), .scene(scene),
        .teach_req(teach_req), .feat_thd(feat_thd), .feat_power(feat_power),
        .feat_power_ratio(feat_power_ratio), .feat_freq(feat_freq),
        .teach_end(teach_end));
    task automatic end_sim;
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, x);
        num_checks++;
        if (got !== x) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, x, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, x);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask
    initial begin
        wt(5);
        presetn <= 1'b1;
        wt(1);
        rd(8'h04, 32'h10);
        rd(8'h08, 32'h1);
        rd(8'h0C, 32'h320);
        rd(8'h2C, 32'h7FF9);
        apb(1'b0, 8'h3C, 32'h0);
        chk("slverr", e, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(ca[i], {16'h0, cw[i]});
            rd(ca[i], {16'h0, ce[i]});
        end
        for (int i = 0; i < 8; i++)
            wr(8'h10 + {i[5:0], 2'b00}, {16'h0, th[i]});
        scene <= {16'h09C4, 16'h0037, 16'h0065, 16'h01F4};
        wt(3 * SC);
        chk("alarm", alarm_flags, 32'h9E);
        chk("alarm", alarm_flags, 32'h9E);
        wr(8'h30, 32'h0);
        rd(8'h30, 32'h9E);
        rd(8'h34, 32'hBE);
        chk("irq", irq, 32'h0);
        wr(8'h38, 32'h2);
        wt(2);
        chk("irq", irq, 32'h1);
        wr(8'h34, 32'h2);
        wt(2);
        chk("irq", irq, 32'h0);
        wr(8'h34, 32'hFF);
        wr(8'h04, 32'h6);
        rd(8'h04, 32'h10);
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h6);
        wr(8'h00, 32'h3);
        rd(8'h00, 32'h2);
        rd(8'h04, 32'h6);
        wr(8'h08, 32'h7FF);
        rd(8'h08, 32'h7D0);
        wr(8'h0C, 32'h64);
        rd(8'h0C, 32'hC8);
        wr(8'h08, 32'h2);
        chk("wiring", wiring_configuration, 32'h0);
        wr(8'h00, 32'h0);
        chk("level", settings_level_indicator, 32'h0);
        chk("wiring", wiring_configuration, 32'h2);
        chk("vrange", voltage_range, 32'h1);
        chk("i5a", current_5a, 32'h0);
        chk("alarm", alarm_flags, 32'h0);
        wt(4 * SC);
        chk("alarm", alarm_flags, 32'h9E);
        rd(8'h34, 32'h9E);
        scene <= {16'h09C4, 16'hFFCE, 16'h01F4, 16'h03E8};
        wt(2);
        teach_req <= 1'b1;
        wt(3);
        rd(8'h10, 32'hC8);
        rd(8'h18, 32'h64);
        rd(8'h20, 32'hFFF6);
        rd(8'h28, 32'h1F4);
        end_sim();
    end
endmodule // tb
